// ===== core/spi_eeprom_front.sv
// Serial EEPROM front end: opcode decode, address, read out, write cycle
//
// Contract
// R1 - opcode held in eight-bit instruction register
// R2 - first byte after select is opcode
// R3 - input bits sampled on rising clock
// R4 - read data changes on falling clock
// R5 - output floats while select is high
// R6 - new sequence only after select falls
// R7 - write cycle starts at select rising
// R8 - write cycle lasts at most 10 ms
// R9 - latch and status opcodes decoded exactly; with ADDR_BITS 9 the code masks bit 3 from them as well
// R10 - memory read opcode, bit 3 address
// R11 - memory write opcode, bit 3 address
// R12 - 8 or 16 address clocks, upper ignored
// R13 - host waits 1 ms after power-up
// R14 - write latch set, cleared, gates writes
// R15 - status bit 0 shows write busy
// R16 - only status read while busy
// R17 - protect bits guard quarter, half, all
// R18 - unknown opcode ignored until deselect
// R19 - sequential read wraps to zero
//
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
module spi_eeprom_front #(
  parameter int ADDR_BITS = 11,
  parameter int WRITE_CYCLES = spi_eeprom_pkg::WRITE_CYCLES
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // Serial link
  spi_link_if.device link,
  // Device state
  output logic write_busy,
  output logic write_latch,
  output logic [1:0] protect_level,
  output logic hw_protect_enable
);
  localparam int ADDR_CLKS = (ADDR_BITS > 8) ? 16 : 8;
  localparam logic [3:0] ADDR_LAST = 4'(ADDR_CLKS - 1);
  localparam int CNT_W = $clog2(WRITE_CYCLES + 1);

  spi_eeprom_pkg::dev_state_t state;
  logic [3:0] bit_cnt;
  logic [7:0] op_reg;
  logic [7:0] op_kind;
  logic [7:0] op_norm;
  logic [15:0] sh;
  logic [15:0] next_sh;
  logic [ADDR_BITS-1:0] addr_next;
  logic [ADDR_BITS-1:0] addr_q;
  logic op_done;
  logic addr_done;
  logic data_done;
  logic commit_latch;
  logic busy_s1;
  logic busy_sck;
  logic res_tog;
  logic [7:0] res_op;
  logic [7:0] res_data;
  logic [ADDR_BITS-1:0] res_addr;
  logic rd_active;
  logic rd_status;
  logic [2:0] out_idx;
  logic [7:0] out_byte;
  logic [ADDR_BITS-1:0] rd_ptr;
  logic [ADDR_BITS-1:0] next_ptr;
  logic [7:0] status_now;
  logic [7:0] mem [0:(1<<ADDR_BITS)-1];
  logic cs_s1;
  logic cs_s2;
  logic tog_s1;
  logic tog_s2;
  logic tog_seen;
  logic take;
  logic [CNT_W-1:0] wc_cnt;
  logic wr_pend;
  logic [ADDR_BITS-1:0] wr_addr;
  logic [7:0] wr_data;

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  // R3 rising edge sampling
  assign next_sh = {sh[14:0], link.si};
  // R10 bit 3 dropped
  assign op_norm = (ADDR_BITS == 9) ? (next_sh[7:0] & ~spi_eeprom_pkg::OP_A8_MASK) : next_sh[7:0];
  assign op_done = (state == spi_eeprom_pkg::D_OP) && (bit_cnt == 4'h7);
  assign addr_done = (state == spi_eeprom_pkg::D_ADDR) && (bit_cnt == ADDR_LAST);
  assign data_done = (state == spi_eeprom_pkg::D_DATA) && (bit_cnt == 4'h7);
  // R9 latch opcodes
  assign commit_latch = op_done && !busy_sck
    && (op_norm == spi_eeprom_pkg::OP_SET_LATCH || op_norm == spi_eeprom_pkg::OP_CLR_LATCH);
  assign next_ptr = rd_ptr + 1'b1;
  // R15 busy in bit 0
  assign status_now = spi_eeprom_pkg::STAT_FIXED
    | {hw_protect_enable, 3'h0, protect_level, write_latch, busy_sck};

  generate
    if (ADDR_BITS == 9)
    begin : g_a8
      // R11 bit 3 is address 8
      assign addr_next = {op_reg[3], next_sh[7:0]};
    end
    else
    begin : g_plain
      // R12 upper bits ignored
      assign addr_next = next_sh[ADDR_BITS-1:0];
    end
  endgenerate

  function automatic logic prot_hit(input logic [1:0] lvl, input logic [ADDR_BITS-1:0] a);
    prot_hit = (lvl == 2'h3) || (lvl == 2'h2 && a[ADDR_BITS-1])
      || (lvl == 2'h1 && a[ADDR_BITS-1] && a[ADDR_BITS-2]);
  endfunction

  // ----------------------------------------
  // Sequence decoder on the serial clock
  // ----------------------------------------
  // R6 restart on select fall
  always_ff @(posedge link.sck or posedge link.cs_n)
  begin
    if (link.cs_n)
    begin
      state <= spi_eeprom_pkg::D_OP;
      bit_cnt <= 4'h0;
      op_reg <= 8'h00;
      op_kind <= 8'h00;
      addr_q <= '0;
    end
    else
    begin
      case (state)
        spi_eeprom_pkg::D_OP:
        begin
          bit_cnt <= bit_cnt + 4'h1;
          if (op_done)
          begin
            bit_cnt <= 4'h0;
            // R1 instruction register
            op_reg <= next_sh[7:0];
            op_kind <= op_norm;
            // R16 busy blocks all but status read
            if (busy_sck)
              state <= spi_eeprom_pkg::D_IGNORE;
            // R2 opcode selects operation
            else if (op_norm == spi_eeprom_pkg::OP_MEM_RD || op_norm == spi_eeprom_pkg::OP_MEM_WR)
              state <= spi_eeprom_pkg::D_ADDR;
            else if (op_norm == spi_eeprom_pkg::OP_STAT_WR)
              state <= spi_eeprom_pkg::D_DATA;
            // R18 others wait for deselect
            else
              state <= spi_eeprom_pkg::D_IGNORE;
          end
        end
        spi_eeprom_pkg::D_ADDR:
        begin
          bit_cnt <= bit_cnt + 4'h1;
          if (addr_done)
          begin
            bit_cnt <= 4'h0;
            addr_q <= addr_next;
            if (op_kind == spi_eeprom_pkg::OP_MEM_RD)
              state <= spi_eeprom_pkg::D_IGNORE;
            else
              state <= spi_eeprom_pkg::D_DATA;
          end
        end
        spi_eeprom_pkg::D_DATA:
        begin
          bit_cnt <= bit_cnt + 4'h1;
          if (data_done)
            state <= spi_eeprom_pkg::D_IGNORE;
        end
        spi_eeprom_pkg::D_IGNORE:
          bit_cnt <= bit_cnt;
        default:
          state <= spi_eeprom_pkg::D_IGNORE;
      endcase
    end
  end

  // ----------------------------------------
  // Shift register, busy sync, frame result
  // ----------------------------------------
  always_ff @(posedge link.sck or negedge aresetn)
  begin
    if (!aresetn)
    begin
      sh <= 16'h0000;
      busy_s1 <= 1'b0;
      busy_sck <= 1'b0;
      res_tog <= 1'b0;
      res_op <= 8'h00;
      res_data <= 8'h00;
      res_addr <= '0;
    end
    else
    begin
      sh <= next_sh;
      busy_s1 <= write_busy;
      busy_sck <= busy_s1;
      if (commit_latch || (data_done && !link.cs_n))
      begin
        res_tog <= ~res_tog;
        res_op <= commit_latch ? op_norm : op_kind;
        res_data <= next_sh[7:0];
        res_addr <= addr_q;
      end
    end
  end

  // ----------------------------------------
  // Read data path
  // ----------------------------------------
  always_ff @(posedge link.sck or posedge link.cs_n)
  begin
    if (link.cs_n)
    begin
      rd_active <= 1'b0;
      rd_status <= 1'b0;
      out_idx <= 3'h7;
      out_byte <= 8'h00;
      rd_ptr <= '0;
    end
    else if (op_done && op_norm == spi_eeprom_pkg::OP_STAT_RD)
    begin
      rd_active <= 1'b1;
      rd_status <= 1'b1;
      out_byte <= status_now;
    end
    else if (addr_done && op_kind == spi_eeprom_pkg::OP_MEM_RD)
    begin
      rd_active <= 1'b1;
      rd_ptr <= addr_next;
      out_byte <= mem[addr_next];
    end
    else if (rd_active)
    begin
      out_idx <= out_idx - 3'h1;
      if (out_idx == 3'h0)
      begin
        if (rd_status)
          out_byte <= status_now;
        else
        begin
          // R19 incrementing wrap read
          rd_ptr <= next_ptr;
          out_byte <= mem[next_ptr];
        end
      end
    end
  end

  // R4 falling edge output
  // R5 float when deselected
  always_ff @(negedge link.sck or posedge link.cs_n)
  begin
    if (link.cs_n)
    begin
      link.so_out <= 1'b0;
      link.so_oe <= 1'b0;
    end
    else
    begin
      link.so_out <= out_byte[out_idx];
      link.so_oe <= rd_active;
    end
  end

  // ----------------------------------------
  // Crossing into the core clock
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      tog_s1 <= 1'b0;
      tog_s2 <= 1'b0;
    end
    else if (clk_en)
    begin
      cs_s1 <= link.cs_n;
      cs_s2 <= cs_s1;
      tog_s1 <= res_tog;
      tog_s2 <= tog_s1;
    end
  end

  // R7 act only after select rises
  assign take = cs_s2 && (tog_s2 != tog_seen);

  // ----------------------------------------
  // Status register and write cycle
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tog_seen <= 1'b0;
      write_latch <= 1'b0;
      write_busy <= 1'b0;
      protect_level <= spi_eeprom_pkg::PROT_RESET;
      hw_protect_enable <= 1'b0;
      wc_cnt <= '0;
      wr_pend <= 1'b0;
      wr_addr <= '0;
      wr_data <= 8'h00;
    end
    else if (clk_en)
    begin
      if (take)
        tog_seen <= tog_s2;
      // R8 bounded write cycle
      if (write_busy)
      begin
        wc_cnt <= wc_cnt - 1'b1;
        if (wc_cnt == CNT_W'(1))
        begin
          write_busy <= 1'b0;
          wr_pend <= 1'b0;
        end
      end
      // R16 commands dropped while busy
      else if (take)
      begin
        case (res_op)
          // R14 latch set and clear
          spi_eeprom_pkg::OP_SET_LATCH:
            write_latch <= 1'b1;
          spi_eeprom_pkg::OP_CLR_LATCH:
            write_latch <= 1'b0;
          spi_eeprom_pkg::OP_STAT_WR:
            if (write_latch)
            begin
              // R17 protect bits by status write
              protect_level <= res_data[spi_eeprom_pkg::ST_PROT_HI:spi_eeprom_pkg::ST_PROT_LO];
              hw_protect_enable <= res_data[spi_eeprom_pkg::ST_HW_EN];
              write_latch <= 1'b0;
              write_busy <= 1'b1;
              wc_cnt <= CNT_W'(WRITE_CYCLES);
            end
          spi_eeprom_pkg::OP_MEM_WR:
            // R14 latch gates writes
            if (write_latch)
            begin
              write_latch <= 1'b0;
              // R17 protected area refused
              if (!prot_hit(protect_level, res_addr))
              begin
                write_busy <= 1'b1;
                wc_cnt <= CNT_W'(WRITE_CYCLES);
                wr_pend <= 1'b1;
                wr_addr <= res_addr;
                wr_data <= res_data;
              end
            end
          default:
            write_latch <= write_latch;
        endcase
      end
    end
  end

  // Cell array update at the end of the write cycle
  always_ff @(posedge aclk)
  begin
    if (clk_en && write_busy && wr_pend && wc_cnt == CNT_W'(1))
      mem[wr_addr] <= wr_data;
  end

endmodule

// ===== shared/spi_eeprom_pkg.sv
// Shared constants for the serial EEPROM front end and its host
package spi_eeprom_pkg;

  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int ACLK_MHZ = 125;
  localparam int WRITE_MS_WIDE = 10;
  localparam int WRITE_MS_HIGH = 5;
  localparam int WRITE_CYCLES = WRITE_MS_WIDE * 1000 * ACLK_MHZ;
  localparam int POWERUP_MS = 1;
  localparam int POWERUP_CYCLES = POWERUP_MS * 1000 * ACLK_MHZ;
  localparam int SCK_HALF_NS = 50;
  localparam int SCK_HALF_CYCLES = (SCK_HALF_NS * ACLK_MHZ + 999) / 1000;
  localparam int CS_GAP_NS = 100;
  localparam int CS_GAP_CYCLES = (CS_GAP_NS * ACLK_MHZ + 999) / 1000;

  // ----------------------------------------
  // Opcodes
  // ----------------------------------------
  localparam logic [7:0] OP_SET_LATCH = 8'h06;
  localparam logic [7:0] OP_CLR_LATCH = 8'h04;
  localparam logic [7:0] OP_STAT_RD = 8'h05;
  localparam logic [7:0] OP_STAT_WR = 8'h01;
  localparam logic [7:0] OP_MEM_RD = 8'h03;
  localparam logic [7:0] OP_MEM_WR = 8'h02;
  localparam logic [7:0] OP_A8_MASK = 8'h08;

  // ----------------------------------------
  // Status byte layout
  // ----------------------------------------
  localparam int ST_BUSY = 0;
  localparam int ST_LATCH = 1;
  localparam int ST_PROT_LO = 2;
  localparam int ST_PROT_HI = 3;
  localparam int ST_HW_EN = 7;
  localparam logic [7:0] STAT_FIXED = 8'h20;
  localparam logic [1:0] PROT_RESET = 2'h0;

  // ----------------------------------------
  // Host register map and bus answers
  // ----------------------------------------
  localparam logic [7:0] REG_TX_WORD = 8'h00;
  localparam logic [7:0] REG_GO = 8'h04;
  localparam logic [7:0] REG_RX_WORD = 8'h08;
  localparam logic [7:0] REG_STATE = 8'h0C;
  localparam int GO_TX_LSB = 0;
  localparam int GO_RX_LSB = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // State encodings
  // ----------------------------------------
  typedef enum logic [3:0] {
    D_OP = 4'h1,
    D_ADDR = 4'h2,
    D_DATA = 4'h4,
    D_IGNORE = 4'h8
  } dev_state_t;

  typedef enum logic [5:0] {
    H_IDLE = 6'h01,
    H_SETUP = 6'h02,
    H_LOW = 6'h04,
    H_HIGH = 6'h08,
    H_HOLD = 6'h10,
    H_GAP = 6'h20
  } host_state_t;

endpackage

// ===== shared/spi_link_if.sv
// Serial link between the host master and the EEPROM front end
`timescale 1ns/1ps
interface spi_link_if;
  logic sck;
  logic cs_n;
  logic si;
  logic so_out;
  logic so_oe;
  logic so;

  // Line level with a pull-up while the output floats
  assign so = so_oe ? so_out : 1'b1;

  modport host (output sck, output cs_n, output si, input so);
  modport device (input sck, input cs_n, input si, output so_out, output so_oe);
endinterface

// ===== core/spi_eeprom_host.sv
// Host master: register-driven SPI frames toward the EEPROM
`timescale 1ns/1ps
module spi_eeprom_host #(
  parameter int POWERUP_CYCLES = spi_eeprom_pkg::POWERUP_CYCLES,
  parameter int HALF_CYCLES = spi_eeprom_pkg::SCK_HALF_CYCLES,
  parameter int GAP_CYCLES = spi_eeprom_pkg::CS_GAP_CYCLES
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Serial link
  spi_link_if.host link
);
  localparam int PU_W = $clog2(POWERUP_CYCLES + 1);

  spi_eeprom_pkg::host_state_t state;
  logic [31:0] tx_word;
  logic [31:0] rx_word;
  logic [31:0] tx_sh;
  logic [2:0] go_tx;
  logic [2:0] go_rx;
  logic pending;
  logic [PU_W-1:0] pu_cnt;
  logic pu_done;
  logic [7:0] cnt;
  logic [5:0] bit_no;
  logic [5:0] bit_total;
  logic so_s1;
  logic so_s2;
  logic aw_hold;
  logic w_hold;
  logic [7:0] aw_q;
  logic [31:0] w_q;
  logic [3:0] ws_q;
  logic do_wr;

  assign do_wr = aw_hold && w_hold && !s_axi_bvalid;

  // ----------------------------------------
  // Write channel and registers
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= spi_eeprom_pkg::RESP_OKAY;
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_q <= 8'h00;
      w_q <= 32'h0000_0000;
      ws_q <= 4'h0;
      tx_word <= 32'h0000_0000;
      go_tx <= 3'h0;
      go_rx <= 3'h0;
      pending <= 1'b0;
    end
    else if (clk_en)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold <= 1'b1;
        aw_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold <= 1'b1;
        w_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (state == spi_eeprom_pkg::H_IDLE && pending && pu_done)
        pending <= 1'b0;
      if (do_wr)
      begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_q > spi_eeprom_pkg::REG_STATE) ? spi_eeprom_pkg::RESP_SLVERR
          : spi_eeprom_pkg::RESP_OKAY;
        if (aw_q[7:2] == spi_eeprom_pkg::REG_TX_WORD[7:2])
        begin
          for (int i = 0; i < 4; i++)
            if (ws_q[i])
              tx_word[i*8 +: 8] <= w_q[i*8 +: 8];
        end
        else if (aw_q[7:2] == spi_eeprom_pkg::REG_GO[7:2] && ws_q[0] && !pending
          && state == spi_eeprom_pkg::H_IDLE && w_q[2:0] != 3'h0)
        begin
          go_tx <= w_q[spi_eeprom_pkg::GO_TX_LSB +: 3];
          go_rx <= w_q[spi_eeprom_pkg::GO_RX_LSB +: 3];
          pending <= 1'b1;
        end
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= spi_eeprom_pkg::RESP_OKAY;
    end
    else if (clk_en)
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= spi_eeprom_pkg::RESP_OKAY;
        case (s_axi_araddr[7:2])
          spi_eeprom_pkg::REG_TX_WORD[7:2]:
            s_axi_rdata <= tx_word;
          spi_eeprom_pkg::REG_GO[7:2]:
            s_axi_rdata <= {25'h0, go_rx, 1'b0, go_tx};
          spi_eeprom_pkg::REG_RX_WORD[7:2]:
            s_axi_rdata <= rx_word;
          spi_eeprom_pkg::REG_STATE[7:2]:
            s_axi_rdata <= {30'h0, pu_done, pending || state != spi_eeprom_pkg::H_IDLE};
          default:
          begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= spi_eeprom_pkg::RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Power-up hold-off and input sync
  // ----------------------------------------
  // R13 power-up wait
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pu_cnt <= PU_W'(POWERUP_CYCLES);
      pu_done <= 1'b0;
      so_s1 <= 1'b1;
      so_s2 <= 1'b1;
    end
    else if (clk_en)
    begin
      so_s1 <= link.so;
      so_s2 <= so_s1;
      if (pu_cnt != '0)
        pu_cnt <= pu_cnt - 1'b1;
      else
        pu_done <= 1'b1;
    end
  end

  // ----------------------------------------
  // Frame engine, mode 0
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= spi_eeprom_pkg::H_IDLE;
      link.sck <= 1'b0;
      link.cs_n <= 1'b1;
      link.si <= 1'b0;
      tx_sh <= 32'h0000_0000;
      rx_word <= 32'h0000_0000;
      cnt <= 8'h00;
      bit_no <= 6'h00;
      bit_total <= 6'h00;
    end
    else if (clk_en)
    begin
      cnt <= cnt - 8'h01;
      case (state)
        spi_eeprom_pkg::H_IDLE:
          // R6 select falls before each frame
          if (pending && pu_done)
          begin
            link.cs_n <= 1'b0;
            link.si <= tx_word[31];
            tx_sh <= {tx_word[30:0], 1'b0};
            bit_no <= 6'h00;
            bit_total <= {go_tx + go_rx, 3'h0};
            cnt <= 8'(GAP_CYCLES - 1);
            state <= spi_eeprom_pkg::H_SETUP;
          end
        spi_eeprom_pkg::H_SETUP, spi_eeprom_pkg::H_LOW:
          if (cnt == 8'h00)
          begin
            // R3 data stable before rising edge
            link.sck <= 1'b1;
            if (bit_no >= {go_tx, 3'h0})
              rx_word <= {rx_word[30:0], so_s2};
            cnt <= 8'(HALF_CYCLES - 1);
            state <= spi_eeprom_pkg::H_HIGH;
          end
        spi_eeprom_pkg::H_HIGH:
          if (cnt == 8'h00)
          begin
            link.sck <= 1'b0;
            bit_no <= bit_no + 6'h01;
            link.si <= tx_sh[31];
            tx_sh <= {tx_sh[30:0], 1'b0};
            // R12 address clocks come from byte count
            if (bit_no + 6'h01 == bit_total)
            begin
              cnt <= 8'(GAP_CYCLES - 1);
              state <= spi_eeprom_pkg::H_HOLD;
            end
            else
            begin
              cnt <= 8'(HALF_CYCLES - 1);
              state <= spi_eeprom_pkg::H_LOW;
            end
          end
        spi_eeprom_pkg::H_HOLD:
          if (cnt == 8'h00)
          begin
            link.cs_n <= 1'b1;
            cnt <= 8'(GAP_CYCLES - 1);
            state <= spi_eeprom_pkg::H_GAP;
          end
        spi_eeprom_pkg::H_GAP:
          if (cnt == 8'h00)
            state <= spi_eeprom_pkg::H_IDLE;
        default:
          state <= spi_eeprom_pkg::H_IDLE;
      endcase
    end
  end

endmodule

// ===== test/spi_link_checker.sv
// Link checker for host and EEPROM front end
`timescale 1ns/1ps
module spi_link_checker (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Serial link
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic so_out,
  input wire logic so_oe,
  input wire logic so
);
  // ------------------------
  // Link properties
  // ------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_so_floats: assert property (cs_n |-> !so_oe && so)
    else $error("so driven while deselected");
  a_so_on_fall: assert property (so_oe && $changed(so_out) |-> $fell(sck))
    else $error("so changed off a falling sck");
  a_oe_on_fall: assert property ($rose(so_oe) |-> $fell(sck) && !cs_n)
    else $error("so enabled off a falling sck");
  a_oe_stands: assert property (so_oe && !cs_n |=> so_oe || cs_n)
    else $error("so released inside frame");
  a_si_at_rise: assert property ($rose(sck) |-> $stable(si))
    else $error("si changed at sck rise");
  a_sck_framed: assert property (sck |-> !cs_n)
    else $error("sck high while deselected");
  a_cs_setup: assert property ($fell(cs_n) |-> !sck [*8])
    else $error("sck too soon after select");
  a_cs_gap: assert property ($rose(cs_n) |-> cs_n [*8])
    else $error("select high time too short");
  a_sck_high: assert property ($rose(sck) |-> sck [*5])
    else $error("sck high time too short");
  c_frame: cover property ($fell(cs_n) ##[1:600] $rose(cs_n));
  c_read: cover property ($rose(so_oe));
  c_zero: cover property (so_oe && !so);
endmodule

// ===== test/spi_eeprom_command_front_end_tb_top.sv
// Bench joining host and EEPROM front end
`timescale 1ns/1ps
module spi_eeprom_command_front_end_tb_top;
  // ------------------------
  // Signals and instances
  // ------------------------
  logic aclk = 1'b0;
  logic aresetn = 1'b1;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rd;
  logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
  logic awr, wr, bv, arr, rv, wb, wl, hw;
  logic [1:0] br, rr, pl;
  int miscompares = 0, samples_checked = 0, cyc = 0;
  spi_link_if link_if();
  spi_eeprom_host #(.POWERUP_CYCLES(50)) spi_eeprom_host_inst (.aclk(aclk),
    .aresetn(aresetn), .clk_en(1'b1), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre), .link(link_if));
  spi_eeprom_front #(.WRITE_CYCLES(2000)) spi_eeprom_front_inst (.aclk(aclk),
    .aresetn(aresetn), .clk_en(1'b1), .link(link_if), .write_busy(wb),
    .write_latch(wl), .protect_level(pl), .hw_protect_enable(hw));
  spi_link_checker spi_link_checker_inst (.aclk(aclk), .aresetn(aresetn),
    .sck(link_if.sck), .cs_n(link_if.cs_n), .si(link_if.si),
    .so_out(link_if.so_out), .so_oe(link_if.so_oe), .so(link_if.so));
  always #4 aclk = ~aclk;
  // ------------------------
  // Bus and frame tasks
  // ------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge aclk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    while (pa || pw)
    begin
      @(posedge aclk);
      if (pa && awr === 1'b1)
      begin
        awv <= 1'b0;
        pa = 1'b0;
      end
      if (pw && wr === 1'b1)
      begin
        wv <= 1'b0;
        pw = 1'b0;
      end
    end
    while (bv !== 1'b1) @(posedge aclk);
    r = br;
    bre <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do @(posedge aclk); while (arr !== 1'b1);
    arv <= 1'b0;
    while (rv !== 1'b1) @(posedge aclk);
    d = rd;
    r = rr;
    rre <= 1'b0;
  endtask
  task automatic fr(input logic [31:0] tx, input logic [2:0] nt, input logic [2:0] nr,
    output logic [31:0] rx);
    logic [1:0] r;
    logic [31:0] s;
    axw(spi_eeprom_pkg::REG_TX_WORD, tx, r);
    axw(spi_eeprom_pkg::REG_GO, {25'h0, nr, 1'b0, nt}, r);
    s = 32'h1;
    for (int i = 0; i < 400 && s[0] !== 1'b0; i++) axr(spi_eeprom_pkg::REG_STATE, s, r);
    axr(spi_eeprom_pkg::REG_RX_WORD, rx, r);
  endtask
  task automatic st(input logic [7:0] exp);
    logic [31:0] w;
    fr(32'h05000000, 3'h1, 3'h1, w);
    chk(w[7:0], exp);
  endtask
  task automatic wt();
    logic [31:0] w;
    w = 32'h1;
    for (int i = 0; i < 40 && w[0] !== 1'b0; i++) fr(32'h05000000, 3'h1, 3'h1, w);
    chk(w[0], 1'b0);
  endtask
  // ------------------------
  // Scenarios
  // ------------------------
  task automatic t_boot();
    logic [31:0] d;
    logic [1:0] r;
    axr(spi_eeprom_pkg::REG_STATE, d, r);
    chk(d[1], 1'b0);
    for (int i = 0; i < 40 && d[1] !== 1'b1; i++) axr(spi_eeprom_pkg::REG_STATE, d, r);
    chk(d[1], 1'b1);
    axr(8'h10, d, r);
    chk(r, spi_eeprom_pkg::RESP_SLVERR);
    axw(8'h10, 32'h0, r);
    chk(r, spi_eeprom_pkg::RESP_SLVERR);
    st(8'h20);
  endtask
  task automatic t_latch();
    logic [31:0] w;
    fr(32'h06000000, 3'h1, 3'h0, w);
    chk(wl, 1'b1);
    st(8'h22);
    fr(32'h04000000, 3'h1, 3'h0, w);
    st(8'h20);
    fr(32'h07000000, 3'h1, 3'h0, w);
    st(8'h20);
    fr(32'h0200105A, 3'h4, 3'h0, w);
    st(8'h20);
  endtask
  task automatic t_write();
    logic [31:0] w;
    fr(32'h06000000, 3'h1, 3'h0, w);
    fr(32'h02F800A5, 3'h4, 3'h0, w);
    chk(wb, 1'b1);
    st(8'h21);
    fr(32'h06000000, 3'h1, 3'h0, w);
    st(8'h21);
    wt();
    fr(32'h06000000, 3'h1, 3'h0, w);
    fr(32'h0207FF3C, 3'h4, 3'h0, w);
    wt();
    fr(32'h0307FF00, 3'h3, 3'h2, w);
    chk(w[15:0], 16'h3CA5);
  endtask
  task automatic t_protect();
    logic [31:0] w;
    fr(32'h06000000, 3'h1, 3'h0, w);
    fr(32'h01040000, 3'h2, 3'h0, w);
    chk(pl, 2'h1);
    chk(hw, 1'b0);
    wt();
    st(8'h24);
    fr(32'h06000000, 3'h1, 3'h0, w);
    fr(32'h0207FF00, 3'h4, 3'h0, w);
    wt();
    fr(32'h0307FF00, 3'h3, 3'h1, w);
    chk(w[7:0], 8'h3C);
  endtask
  // ------------------------
  // Run control
  // ------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      miscompares++;
      end_sim();
    end
  end
  initial
  begin
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_boot();
    t_latch();
    t_write();
    t_protect();
    end_sim();
  end
endmodule
